/* File: hdl/radio_ctrl_pkg.sv */
`default_nettype none
package radio_ctrl_pkg;

    // ==========================================================
    // Register map: printed offsets are indexes, byte address x4
    // ==========================================================
    localparam logic [7:0] IDX_SM_CONFIG_ONE = 8'h17;
    localparam logic [7:0] IDX_SM_CONFIG_ZERO = 8'h18;
    localparam logic [7:0] IDX_STATUS = 8'h19;
    localparam logic [7:0] IDX_COMMAND = 8'h1a;
    localparam logic [31:0] ADDR_SM_CONFIG_ONE = {22'h0, IDX_SM_CONFIG_ONE, 2'b00};
    localparam logic [31:0] ADDR_SM_CONFIG_ZERO = {22'h0, IDX_SM_CONFIG_ZERO, 2'b00};
    localparam logic [31:0] ADDR_STATUS = {22'h0, IDX_STATUS, 2'b00};
    localparam logic [31:0] ADDR_COMMAND = {22'h0, IDX_COMMAND, 2'b00};

    // ==========================================================
    // Reset values (bits 5:0 held; 7:6 always read zero)
    // ==========================================================
    localparam logic [5:0] SM_CONFIG_ONE_RESET = 6'h30;
    localparam logic [5:0] SM_CONFIG_ZERO_RESET = 6'h04;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int CLEAR_MODE_LSB = 4;
    localparam int AFTER_RX_LSB = 2;
    localparam int AFTER_TX_LSB = 0;
    localparam int AUTOCAL_LSB = 4;
    localparam int CMD_RX = 0;
    localparam int CMD_TX = 1;
    localparam int CMD_SYNTH = 2;
    localparam int CMD_IDLE = 3;
    localparam int CMD_CAL = 4;

    // ==========================================================
    // Field encodings
    // ==========================================================
    localparam logic [1:0] CLEAR_ALWAYS = 2'h0;
    localparam logic [1:0] CLEAR_RSSI = 2'h1;
    localparam logic [1:0] CLEAR_NOT_RX = 2'h2;
    localparam logic [1:0] NEXT_IDLE = 2'h0;
    localparam logic [1:0] NEXT_SYNTH = 2'h1;
    localparam logic [1:0] NEXT_TX = 2'h2;
    localparam logic [1:0] NEXT_STAY_OR_RX = 2'h3;
    localparam logic [1:0] AUTOCAL_NEVER = 2'h0;
    localparam logic [1:0] AUTOCAL_FROM_IDLE = 2'h1;
    localparam logic [1:0] AUTOCAL_TO_IDLE = 2'h2;
    localparam logic [1:0] AUTOCAL_FOURTH = 2'h3;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 10;
    localparam int CAL_TIME_NS = 1000;
    localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CAL,
        ST_RX,
        ST_TX,
        ST_SYNTH
    } radio_state_t;

endpackage
`default_nettype wire

/* File: hdl/cal_if.sv */
`default_nettype none
interface cal_if;
    logic [1:0] mode;
    logic enter_active;
    logic auto_idle;
    logic manual;
    logic start;
    logic busy;

    modport ctrl (
        output mode,
        output enter_active,
        output auto_idle,
        output manual,
        input start,
        input busy
    );
    modport cal (
        input mode,
        input enter_active,
        input auto_idle,
        input manual,
        output start,
        output busy
    );
endinterface
`default_nettype wire

/* File: hdl/synth_cal.sv */
`default_nettype none
module synth_cal #(
    parameter int CAL_LEN = radio_ctrl_pkg::CAL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    cal_if.cal cal
);
    import radio_ctrl_pkg::*;

    localparam int CW = $clog2(CAL_LEN + 1);

    typedef struct packed {
        logic [1:0] returns;
        logic [CW-1:0] timer;
    } cal_state_t;

    cal_state_t s_q;
    cal_state_t s_d;

    // ==========================================================
    // Start decision
    // ==========================================================
    // autocal encoding
    always_comb begin
        cal.start = cal.manual
            | (cal.enter_active & (cal.mode == AUTOCAL_FROM_IDLE))
            | (cal.auto_idle & (cal.mode == AUTOCAL_TO_IDLE))
            | (cal.auto_idle & (cal.mode == AUTOCAL_FOURTH)
               & (s_q.returns == 2'h3));
    end

    assign cal.busy = (s_q.timer != '0);

    // Timer and return counter; counter only moves in mode 3
    always_comb begin
        s_d = s_q;
        if (s_q.timer != '0) begin
            s_d.timer = s_q.timer - 1'b1;
        end
        if (cal.start) begin
            s_d.timer = CW'(CAL_LEN);
        end
        if (cal.auto_idle && cal.mode == AUTOCAL_FOURTH) begin
            s_d.returns = s_q.returns + 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

/* File: hdl/radio_ctrl_top.sv */
`default_nettype none
// Behaviour
// - Clear-channel mode (reset 3) selects always, low RSSI, not receiving, or both.
// - The clear-channel output follows the indication of the selected mode.
// - After a received packet the radio goes to IDLE, synth-ready, TX or stays in RX.
// - After a sent packet the radio goes to IDLE, synth-ready, TX with new preamble, or RX.
// - The second config register holds the automatic calibration select.
// - Autocal 0 manual only, 1 leaving IDLE, 2 auto return to IDLE, 3 every fourth return.
module radio_ctrl_top #(
    parameter int CAL_LEN = radio_ctrl_pkg::CAL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rssi_below_threshold,
    input wire logic pkt_receiving,
    input wire logic rx_pkt_done,
    input wire logic tx_pkt_done,
    output logic clear_channel_flag,
    output radio_ctrl_pkg::radio_state_t radio_state,
    output logic preamble_restart,
    output logic calibrating
);
    import radio_ctrl_pkg::*;

    typedef struct packed {
        radio_state_t st;
        radio_state_t target;
        logic [5:0] sm_one;
        logic [5:0] sm_zero;
        logic [4:0] cmd;
        logic wr_pend;
        logic [1:0] wr_sel;
        logic [31:0] rdata;
        logic flag;
        logic preamble;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;
    cal_if cal_bus ();

    logic [1:0] clear_mode;
    logic [1:0] after_rx;
    logic [1:0] after_tx;
    logic [1:0] sel;
    logic [31:0] read_val;

    assign clear_mode = s_q.sm_one[CLEAR_MODE_LSB +: 2];
    assign after_rx = s_q.sm_one[AFTER_RX_LSB +: 2];
    assign after_tx = s_q.sm_one[AFTER_TX_LSB +: 2];
    // autocal select lives in the second config register
    assign cal_bus.mode = s_q.sm_zero[AUTOCAL_LSB +: 2];

    synth_cal #(
        .CAL_LEN(CAL_LEN)
    ) u_cal (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cal(cal_bus)
    );

    // ==========================================================
    // Bus slave: zero wait, always OKAY
    // ==========================================================
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign clear_channel_flag = s_q.flag;
    assign radio_state = s_q.st;
    assign preamble_restart = s_q.preamble;
    assign calibrating = (s_q.st == ST_CAL);

    // Address decode; sel 0 means unmapped or not writable
    // upper bits come back as zero
    always_comb begin
        sel = 2'h0;
        read_val = 32'h0;
        if (haddr == ADDR_SM_CONFIG_ONE) begin
            sel = 2'h1;
            read_val = {26'h0, s_q.sm_one};
        end else if (haddr == ADDR_SM_CONFIG_ZERO) begin
            sel = 2'h2;
            read_val = {26'h0, s_q.sm_zero};
        end else if (haddr == ADDR_COMMAND) begin
            sel = 2'h3;
        end else if (haddr == ADDR_STATUS) begin
            read_val = {26'h0, s_q.flag, cal_bus.busy, 1'b0, s_q.st};
        end
    end

    // ==========================================================
    // Next state: bus, clear channel, radio state machine
    // ==========================================================
    always_comb begin
        s_d = s_q;
        s_d.cmd = 5'h0;
        s_d.preamble = 1'b0;
        s_d.wr_pend = 1'b0;
        cal_bus.enter_active = 1'b0;
        cal_bus.auto_idle = 1'b0;
        cal_bus.manual = 1'b0;

        // Write data phase; keeps bits 7:6 out of storage
        if (s_q.wr_pend) begin
            if (s_q.wr_sel == 2'h1) begin
                s_d.sm_one = hwdata[5:0];
            end else if (s_q.wr_sel == 2'h2) begin
                s_d.sm_zero = hwdata[5:0];
            end else if (s_q.wr_sel == 2'h3) begin
                s_d.cmd = hwdata[4:0];
            end
        end

        // Address phase; read data is captured here for the next edge
        if (hsel && hready && htrans[1]) begin
            s_d.wr_pend = hwrite;
            s_d.wr_sel = sel;
            if (!hwrite) begin
                s_d.rdata = read_val;
            end
        end

        case (clear_mode)
            CLEAR_ALWAYS: s_d.flag = 1'b1;
            CLEAR_RSSI: s_d.flag = rssi_below_threshold;
            CLEAR_NOT_RX: s_d.flag = !pkt_receiving;
            default: s_d.flag = rssi_below_threshold && !pkt_receiving;
        endcase

        case (s_q.st)
            ST_IDLE: begin
                if (s_q.cmd[CMD_CAL]) begin
                    // manual strobe works in every mode
                    cal_bus.manual = 1'b1;
                    s_d.st = ST_CAL;
                    s_d.target = ST_IDLE;
                end else if (s_q.cmd[CMD_RX] || s_q.cmd[CMD_TX]
                             || s_q.cmd[CMD_SYNTH]) begin
                    cal_bus.enter_active = 1'b1;
                    if (s_q.cmd[CMD_RX]) begin
                        s_d.target = ST_RX;
                    end else if (s_q.cmd[CMD_TX]) begin
                        s_d.target = ST_TX;
                    end else begin
                        s_d.target = ST_SYNTH;
                    end
                    s_d.st = cal_bus.start ? ST_CAL : s_d.target;
                end
            end
            ST_CAL: begin
                if (!cal_bus.busy) begin
                    s_d.st = s_q.target;
                end
            end
            ST_RX: begin
                if (s_q.cmd[CMD_IDLE]) begin
                    s_d.st = ST_IDLE;
                end else if (s_q.cmd[CMD_TX]) begin
                    s_d.st = ST_TX;
                end else if (rx_pkt_done) begin
                    case (after_rx)
                        NEXT_IDLE: begin
                            cal_bus.auto_idle = 1'b1;
                            s_d.target = ST_IDLE;
                            s_d.st = cal_bus.start ? ST_CAL : ST_IDLE;
                        end
                        NEXT_SYNTH: s_d.st = ST_SYNTH;
                        NEXT_TX: s_d.st = ST_TX;
                        default: s_d.st = ST_RX;
                    endcase
                end
            end
            ST_TX: begin
                if (s_q.cmd[CMD_IDLE]) begin
                    s_d.st = ST_IDLE;
                end else if (s_q.cmd[CMD_RX]) begin
                    s_d.st = ST_RX;
                end else if (tx_pkt_done) begin
                    case (after_tx)
                        NEXT_IDLE: begin
                            cal_bus.auto_idle = 1'b1;
                            s_d.target = ST_IDLE;
                            s_d.st = cal_bus.start ? ST_CAL : ST_IDLE;
                        end
                        NEXT_SYNTH: s_d.st = ST_SYNTH;
                        NEXT_TX: s_d.preamble = 1'b1;
                        default: s_d.st = ST_RX;
                    endcase
                end
            end
            ST_SYNTH: begin
                if (s_q.cmd[CMD_IDLE]) begin
                    s_d.st = ST_IDLE;
                end else if (s_q.cmd[CMD_TX]) begin
                    s_d.st = ST_TX;
                end else if (s_q.cmd[CMD_RX]) begin
                    s_d.st = ST_RX;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // Register everything; clear-channel flag starts as not clear
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.target <= ST_IDLE;
            s_q.sm_one <= SM_CONFIG_ONE_RESET;
            s_q.sm_zero <= SM_CONFIG_ZERO_RESET;
        end else begin
            s_q <= s_d;
        end
    end

endmodule
`default_nettype wire

/* File: verification/radio_ctrl_chk.sv */
`default_nettype none
module radio_ctrl_chk #(
    parameter int CAL_LEN = radio_ctrl_pkg::CAL_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic rssi_below_threshold,
    input wire logic pkt_receiving,
    input wire logic tx_pkt_done,
    input wire logic clear_channel_flag,
    input wire radio_ctrl_pkg::radio_state_t radio_state,
    input wire logic preamble_restart,
    input wire logic calibrating
);
    timeunit 1ns;
    timeprecision 1ns;
    import radio_ctrl_pkg::*;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Cycles spent calibrating, cleared outside calibration
    int cal_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !calibrating) cal_cnt_q <= 0;
        else cal_cnt_q <= cal_cnt_q + 1;
    end

    // ==========================================================
    // Properties
    // ==========================================================
    sequence rd_cfg;
        hsel && hready && htrans[1] && !hwrite &&
        (haddr == ADDR_SM_CONFIG_ONE || haddr == ADDR_SM_CONFIG_ZERO);
    endsequence
    sequence tx_restart;
        radio_state == ST_TX && tx_pkt_done ##1 radio_state == ST_TX;
    endsequence

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or error response");
    cfg_upper_a: assert property (rd_cfg |=> hrdata[31:6] == 0)
        else $error("config upper bits not zero");
    flag_clear_a: assert property ($past(rst_n) &&
        $past(rssi_below_threshold && !pkt_receiving) |-> clear_channel_flag)
        else $error("flag low while channel clear");
    flag_busy_a: assert property ($past(rst_n) && !clear_channel_flag
        |-> $past(!rssi_below_threshold || pkt_receiving))
        else $error("flag low without cause");
    preamble_cause_a: assert property (preamble_restart |->
        $past(radio_state == ST_TX && tx_pkt_done) && radio_state == ST_TX)
        else $error("preamble restart without sent packet");
    cal_entry_a: assert property ($rose(calibrating) |->
        $past(radio_state) inside {ST_IDLE, ST_RX, ST_TX})
        else $error("calibration entered from wrong state");
    cal_max_a: assert property (calibrating |-> cal_cnt_q <= CAL_LEN)
        else $error("calibration too long");
    cal_min_a: assert property ($fell(calibrating) |->
        $past(cal_cnt_q) >= CAL_LEN - 1)
        else $error("calibration too short");
    cover property (tx_restart);
endmodule

bind radio_ctrl_top radio_ctrl_chk #(.CAL_LEN(CAL_LEN)) chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rssi_below_threshold(rssi_below_threshold),
    .pkt_receiving(pkt_receiving), .tx_pkt_done(tx_pkt_done),
    .clear_channel_flag(clear_channel_flag), .radio_state(radio_state),
    .preamble_restart(preamble_restart), .calibrating(calibrating));
`default_nettype wire

/* File: verification/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import radio_ctrl_pkg::*;
    logic sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0;
    logic rssi = 0, pkt = 0, rx_done = 0, tx_done = 0;
    logic flag, pre, cal;
    radio_state_t st;
    radio_state_t nx[4] = '{ST_IDLE, ST_SYNTH, ST_TX, ST_RX};
    localparam int TB_CAL = 3;
    int failures = 0, total_checks = 0, n, ret_m = 0;
    integer seed = 32'h47e9;

    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    radio_ctrl_top #(.CAL_LEN(TB_CAL)) uut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rssi_below_threshold(rssi),
        .pkt_receiving(pkt), .rx_pkt_done(rx_done), .tx_pkt_done(tx_done),
        .clear_channel_flag(flag), .radio_state(st),
        .preamble_restart(pre), .calibrating(cal));

    // ==========================================================
    // Compare, bus and stimulus tasks
    // ==========================================================
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_st(radio_state_t e);
        chk("state", 32'(e), 32'(st));
    endtask
    // Single word transfer; the address phase is held until hready
    task automatic bus(logic [31:0] a, logic w, logic [31:0] wd);
        @(posedge sys_clk);
        hsel <= 1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rcheck(logic [31:0] a, logic [31:0] exp);
        bus(a, 0, 32'h0);
        chk("register", exp, rd);
    endtask
    // Command acts one edge after the write is stored
    task automatic cmd(logic [31:0] c);
        bus(ADDR_COMMAND, 1, c);
        @(posedge sys_clk);
        #1;
    endtask
    task automatic pulse(logic r);
        @(posedge sys_clk);
        rx_done <= r;
        tx_done <= !r;
        @(posedge sys_clk);
        rx_done <= 0;
        tx_done <= 0;
        #1;
    endtask
    // Count cycles in calibration, bounded against a hang
    // Calibration holds the state for CAL_LEN + 1 cycles
    task automatic cal_wait();
        chk("calibrating", 32'h1, 32'(cal));
        n = 0;
        while (st === ST_CAL && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk("cal cycles", 32'(TB_CAL + 1), 32'(n));
        chk("calibrating", 32'h0, 32'(cal));
    endtask
    function automatic logic ref_flag(int m);
        case (m)
            0: return 1'b1;
            1: return rssi;
            2: return !pkt;
            default: return rssi && !pkt;
        endcase
    endfunction
    task automatic finish_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog: the sequence needs a few hundred cycles
    initial begin
        #100000;
        failures++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1;
        rcheck(ADDR_SM_CONFIG_ONE, 32'h30);
        rcheck(ADDR_SM_CONFIG_ZERO, 32'h04);
        bus(ADDR_SM_CONFIG_ONE, 1, 32'hffffffff);
        rcheck(ADDR_SM_CONFIG_ONE, 32'h3f);
        bus(ADDR_SM_CONFIG_ZERO, 1, 32'hc0);
        rcheck(ADDR_SM_CONFIG_ZERO, 32'h0);
        rcheck(32'h70, 32'h0);
        // Every clear-channel mode against random radio inputs
        for (int m = 0; m < 4; m++) begin
            bus(ADDR_SM_CONFIG_ONE, 1, 32'(m << 4));
            repeat (16) begin
                @(posedge sys_clk);
                rssi <= 1'($random(seed));
                pkt <= 1'($random(seed));
                @(posedge sys_clk);
                #1;
                chk("flag", 32'(ref_flag(m)), 32'(flag));
            end
        end
        // Every next state after reception and after transmission
        for (int a = 0; a < 8; a++) begin
            bus(ADDR_SM_CONFIG_ONE, 1, a < 4 ? 32'(a << 2) : 32'(a - 4));
            cmd(a < 4 ? 32'h1 : 32'h2);
            chk_st(a < 4 ? ST_RX : ST_TX);
            rcheck(ADDR_STATUS, 32'h20 | 32'(a < 4 ? ST_RX : ST_TX));
            pulse(a < 4);
            chk_st(nx[a % 4]);
            chk("preamble", 32'(a == 6), 32'(pre));
            cmd(32'h8);
            chk_st(ST_IDLE);
        end
        // Calibration when leaving idle
        bus(ADDR_SM_CONFIG_ZERO, 1, 32'h1b);
        rcheck(ADDR_SM_CONFIG_ZERO, 32'h1b);
        cmd(32'h1);
        chk_st(ST_CAL);
        cal_wait();
        chk_st(ST_RX);
        cmd(32'h8);
        // Calibration on automatic return to idle
        bus(ADDR_SM_CONFIG_ZERO, 1, 32'h20);
        bus(ADDR_SM_CONFIG_ONE, 1, 32'h0);
        cmd(32'h1);
        chk_st(ST_RX);
        pulse(1);
        chk_st(ST_CAL);
        cal_wait();
        chk_st(ST_IDLE);
        // Fourth-return mode, counted from a fresh reset
        @(posedge sys_clk);
        rst_n <= 0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1;
        bus(ADDR_SM_CONFIG_ZERO, 1, 32'h30);
        for (int i = 0; i < 4; i++) begin
            cmd(32'h1);
            pulse(1);
            chk_st(ret_m == 3 ? ST_CAL : ST_IDLE);
            ret_m = (ret_m + 1) % 4;
        end
        cal_wait();
        // Manual strobe is the only trigger in mode zero
        bus(ADDR_SM_CONFIG_ZERO, 1, 32'h0);
        cmd(32'h10);
        chk_st(ST_CAL);
        cal_wait();
        chk_st(ST_IDLE);
        // Synth-ready strobe from idle, no calibration in mode zero
        cmd(32'h4);
        chk_st(ST_SYNTH);
        finish_test();
    end
endmodule
`default_nettype wire
